// ---- logic/gp4_defines.svh ----
// Register offsets, field positions, reset values and mode codes of the four-pin port
`ifndef GP4_DEFINES_SVH
`define GP4_DEFINES_SVH

// ==========================================================
// Register offsets, byte-wide access
`define GP4_ADDR_W 3
`define GP4_OFF_DIR 3'h0
`define GP4_OFF_DATA 3'h1
`define GP4_OFF_PIN 3'h2
`define GP4_OFF_PULL 3'h3
`define GP4_OFF_ODR 3'h4
`define GP4_OFF_PFC 3'h5
`define GP4_OFF_MODE 3'h6

// ==========================================================
// Field layout and reset values
`define GP4_PIN_CNT 4
`define GP4_PIN_MSB 3
`define GP4_AE_MSB 3
`define GP4_MODE_MSB 2
`define GP4_RST_PORT 4'h0
`define GP4_RST_AE 4'h0
`define GP4_RST_MODE 3'h7
`define GP4_RESERVED_RD 4'h0
`define GP4_BYTE_ZERO 8'h00

// ==========================================================
// Operating modes
`define GP4_MODE_EXT_LO 3'h4
`define GP4_MODE_EXT_HI 3'h6

// ==========================================================
// Address-enable codes at which each pin turns to address output
`define GP4_AE_PIN3_MIN 4'hC
`define GP4_AE_PIN2_MIN 4'hB
`define GP4_AE_PIN1_MIN 4'hA
`define GP4_AE_PIN0_MIN 4'h9

`endif

// ---- logic/gp4_pin_cell.sv ----
// Output drive, enable and pull-up control for one port pin
`timescale 1ns/1ps
`default_nettype none
module gp4_pin_cell (
  // Configuration
  input wire logic implemented,
  input wire logic extMode,
  input wire logic addrEnable,
  input wire logic dirBit,
  input wire logic dataBit,
  input wire logic pullBit,
  input wire logic odrBit,
  input wire logic addrBit,
  // Pin side
  output logic pinOut,
  output logic pinOe,
  output logic pullupOn,
  output logic isAddress
);
  // ==========================================================
  // Pin function and drive
  logic useAddr;  // Pin carries an address line
  logic isOutput;  // Pin is a port output
  logic level;  // Level that would be driven

  always_comb begin
    useAddr = implemented && extMode && addrEnable;
    isOutput = implemented && !useAddr && dirBit;
    level = useAddr ? addrBit : dataBit;
    isAddress = useAddr;
    pinOut = level;
    // Open drain only pulls low; address lines always push-pull
    if (useAddr) begin
      pinOe = 1'b1;
    end else if (isOutput && odrBit) begin
      pinOe = !level;
      pinOut = 1'b0;
    end else begin
      pinOe = isOutput;
    end
    // Pull-up only for a pin that serves as an input
    pullupOn = implemented && !useAddr && !dirBit && pullBit;
  end
endmodule : gp4_pin_cell
`default_nettype wire

// ---- logic/gp4_pkg.sv ----
// Types shared by the four-pin port design
package gp4_pkg;
  // ==========================================================
  // Bus access kind, one-hot
  typedef enum logic [2:0] {
    GP4_ACC_IDLE = 3'b001,
    GP4_ACC_WRITE = 3'b010,
    GP4_ACC_READ = 3'b100
  } gp4_acc_type;
endpackage : gp4_pkg

// ---- logic/gp4_port.sv ----
// Register file and pin control of a four-pin general-purpose port
`include "gp4_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module gp4_port
  import gp4_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0  // Three-pin variant when set
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [`GP4_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Address lines from the bus controller
  input wire logic [`GP4_PIN_MSB:0] addrHigh,
  // Pins
  input wire logic [`GP4_PIN_MSB:0] pinIn,
  output logic [`GP4_PIN_MSB:0] pinOut,
  output logic [`GP4_PIN_MSB:0] pinOe,
  output logic [`GP4_PIN_MSB:0] pullupOn
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [`GP4_PIN_MSB:0] dir;  // Write-only direction
    logic [`GP4_PIN_MSB:0] data;  // Output latch
    logic [`GP4_PIN_MSB:0] pull;  // Pull-up enables
    logic [`GP4_PIN_MSB:0] odr;  // Open-drain selects
    logic [`GP4_AE_MSB:0] ae;  // Address-output enable select
    logic [`GP4_MODE_MSB:0] mode;  // Operating mode
    logic [7:0] rdata;  // Registered read data
  } gp4_state_type;

  gp4_state_type state_r;
  gp4_state_type state_nxt;

  // ==========================================================
  // Derived signals
  logic [`GP4_PIN_MSB:0] implMask;  // Pins that exist in this variant
  logic [`GP4_PIN_MSB:0] pinSync;  // Synchronised pin levels
  logic [`GP4_PIN_MSB:0] addrEn;  // Per-pin address enable
  logic [`GP4_PIN_MSB:0] pinState;  // Pin-state register view
  logic [`GP4_PIN_MSB:0] isAddr;  // Pins carrying address lines
  logic extMode;  // External-bus mode active
  gp4_acc_type acc;  // Current bus access

  // Small variant has no pin 0 and no address outputs
  assign implMask = SMALL_VARIANT ? 4'hE : 4'hF;

  // ==========================================================
  // Pin synchroniser, pins are asynchronous to the clock
  gp4_sync #(
    .WIDTH(`GP4_PIN_CNT)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  // ==========================================================
  // Mode and address-enable decode
  always_comb begin
    extMode = !SMALL_VARIANT && (state_r.mode >= `GP4_MODE_EXT_LO)
      && (state_r.mode <= `GP4_MODE_EXT_HI);
    addrEn[3] = state_r.ae >= `GP4_AE_PIN3_MIN;
    addrEn[2] = state_r.ae >= `GP4_AE_PIN2_MIN;
    addrEn[1] = state_r.ae >= `GP4_AE_PIN1_MIN;
    addrEn[0] = state_r.ae >= `GP4_AE_PIN0_MIN;
  end

  // ==========================================================
  // Per-pin drive cells
  genvar gi;
  generate
    for (gi = 0; gi < `GP4_PIN_CNT; gi++) begin : g_pin
      gp4_pin_cell u_cell (
        .implemented(implMask[gi]),
        .extMode(extMode),
        .addrEnable(addrEn[gi]),
        .dirBit(state_r.dir[gi]),
        .dataBit(state_r.data[gi]),
        .pullBit(state_r.pull[gi]),
        .odrBit(state_r.odr[gi]),
        .addrBit(addrHigh[gi]),
        .pinOut(pinOut[gi]),
        .pinOe(pinOe[gi]),
        .pullupOn(pullupOn[gi]),
        .isAddress(isAddr[gi])
      );
    end
  endgenerate

  // Pin-state view: latch for outputs, synchronised level for inputs
  assign pinState = ((state_r.dir & state_r.data) | (~state_r.dir & pinSync))
    & implMask;

  // ==========================================================
  // Access decode
  always_comb begin
    if (regWrite) begin
      acc = GP4_ACC_WRITE;
    end else if (regRead) begin
      acc = GP4_ACC_READ;
    end else begin
      acc = GP4_ACC_IDLE;
    end
  end

  // ==========================================================
  // Next state: writes land at the next edge
  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = `GP4_BYTE_ZERO;
    case (acc)
      GP4_ACC_WRITE: begin
        // Upper bits and absent pins ignore writes
        case (regAddr)
          `GP4_OFF_DIR: begin
            // Low four bits replace direction; no readback exists
            state_nxt.dir = regWdata[`GP4_PIN_MSB:0] & implMask;
          end
          `GP4_OFF_DATA: begin
            state_nxt.data = regWdata[`GP4_PIN_MSB:0] & implMask;
          end
          `GP4_OFF_PULL: begin
            state_nxt.pull = regWdata[`GP4_PIN_MSB:0] & implMask;
          end
          `GP4_OFF_ODR: begin
            state_nxt.odr = regWdata[`GP4_PIN_MSB:0] & implMask;
          end
          `GP4_OFF_PFC: begin
            state_nxt.ae = regWdata[`GP4_AE_MSB:0];
          end
          `GP4_OFF_MODE: begin
            state_nxt.mode = regWdata[`GP4_MODE_MSB:0];
          end
          default: begin
            // Read-only or unmapped: nothing stored
          end
        endcase
      end
      GP4_ACC_READ: begin
        // Reserved bits and unmapped addresses read zero
        case (regAddr)
          `GP4_OFF_DIR: state_nxt.rdata = `GP4_BYTE_ZERO;  // Write-only
          `GP4_OFF_DATA: state_nxt.rdata = {`GP4_RESERVED_RD, state_r.data};
          `GP4_OFF_PIN: state_nxt.rdata = {`GP4_RESERVED_RD, pinState};
          `GP4_OFF_PULL: state_nxt.rdata = {`GP4_RESERVED_RD, state_r.pull};
          `GP4_OFF_ODR: state_nxt.rdata = {`GP4_RESERVED_RD, state_r.odr};
          `GP4_OFF_PFC: state_nxt.rdata = {`GP4_RESERVED_RD, state_r.ae};
          `GP4_OFF_MODE: state_nxt.rdata = {5'h00, state_r.mode};
          default: state_nxt.rdata = `GP4_BYTE_ZERO;
        endcase
      end
      GP4_ACC_IDLE: begin
        // Read data stand for one cycle only
      end
      default: begin
      end
    endcase
  end

  // ==========================================================
  // Registers, synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r.dir <= `GP4_RST_PORT;
      state_r.data <= `GP4_RST_PORT;
      state_r.pull <= `GP4_RST_PORT;
      state_r.odr <= `GP4_RST_PORT;
      state_r.ae <= `GP4_RST_AE;
      state_r.mode <= `GP4_RST_MODE;
      state_r.rdata <= `GP4_BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Read data from the register, one cycle after the strobe
  assign regRdata = state_r.rdata;
endmodule : gp4_port
`default_nettype wire

// ---- logic/gp4_sync.sv ----
// Two-flop synchroniser for the pin levels
`timescale 1ns/1ps
`default_nettype none
module gp4_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] meta;  // First stage, read only by the second
    logic [WIDTH-1:0] stable;  // Second stage
  } gp4_sync_state_type;

  gp4_sync_state_type state_r;
  gp4_sync_state_type state_nxt;

  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.meta = asyncIn;
    state_nxt.stable = state_r.meta;
  end

  // Registers, synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign syncOut = state_r.stable;
endmodule : gp4_sync
`default_nettype wire

// ---- sim/gp4_pins_model.sv ----
// Behavioural model of the board around the port pins
`timescale 1ns/1ps
`default_nettype none
module gp4_pins_model (
  // Clock
  input wire logic clock,
  // Port side
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] pullupOn,
  // Board side
  input wire logic [3:0] extVal,
  input wire logic [3:0] extEn,
  output logic [3:0] pinLevel
);
  // Undriven pins wander, so a stale level never passes as valid
  logic [3:0] floatR = 4'h5;
  always @(posedge clock) floatR <= ~floatR;
  // Port drive wins, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pullupOn[i] | floatR[i];
    end
  end
endmodule : gp4_pins_model
`default_nettype wire

// ---- sim/gp4_port_properties.sv ----
// Concurrent checks on the four-pin port boundary
`timescale 1ns/1ps
`default_nettype none
module gp4_port_properties #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // Clock, reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Pins
  input wire logic [3:0] addrHigh,
  input wire logic [3:0] pinIn,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] pullupOn
);
  // Readable bits; pin0 absent in the small variant
  localparam logic [7:0] MASK = SMALL_VARIANT ? 8'h0E : 8'h0F;
  logic [2:0] modeR; // Shadow of operating mode
  logic [3:0] aeR; // Shadow of address enable
  logic [1:0] quietCnt; // Edges the pins held still
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Shadows move on the same edge as the port's own registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modeR <= 3'h7;
      aeR <= 4'h0;
    end else if (regWrite && regAddr == 3'h6) begin
      modeR <= regWdata[2:0];
    end else if (regWrite && regAddr == 3'h5) begin
      aeR <= regWdata[3:0];
    end
  end
  // Pin reads only judged once the synchroniser has caught up
  always_ff @(posedge clock) begin
    if (!rst_n || pinIn != $past(pinIn)) begin
      quietCnt <= 2'h0;
    end else if (quietCnt != 2'h3) begin
      quietCnt <= quietCnt + 2'h1;
    end
  end
  // ==========
  // Register port and pins
  chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  chk_rdata_reserved: assert property (regRead |=> regRdata[7:4] == 4'h0)
    else $error("reserved bits set");
  chk_latch_readback: assert property (regWrite && regAddr == 3'h1 ##1 regRead && regAddr == 3'h1
    |=> regRdata == ($past(regWdata, 2) & MASK)) else $error("latch readback");
  chk_pin_state: assert property (regRead && regAddr == 3'h2 && pinOe == 4'h0 &&
    pullupOn == 4'hF && quietCnt == 2'h3 |=> regRdata == ({4'h0, $past(pinIn)} & MASK))
    else $error("pin state read");
  chk_reset_quiet: assert property ($past(rst_n) == 1'b0 |->
    pinOe == 4'h0 && pullupOn == 4'h0 && regRdata == 8'h00) else $error("reset state");
  chk_pull_input_only: assert property ((pullupOn & pinOe) == 4'h0)
    else $error("pull-up on driven pin");
  chk_dir_input: assert property (modeR == 3'h7 && regWrite && regAddr == 3'h0 &&
    regWdata[3:0] == 4'h0 |=> pinOe == 4'h0) else $error("input pin driven");
  chk_addr_pin3: assert property (!SMALL_VARIANT && modeR inside {[3'h4:3'h6]} && aeR >= 4'hC
    |-> pinOe[3] && pinOut[3] == addrHigh[3] && !pullupOn[3]) else $error("address override");
endmodule : gp4_port_properties
bind gp4_port gp4_port_properties #(.SMALL_VARIANT(SMALL_VARIANT)) u_gp4_port_properties (
  .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .addrHigh(addrHigh), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .pullupOn(pullupOn));
`default_nettype wire

// ---- sim/test_gp4_port.sv ----
// Self-checking bench for the four-pin port
`timescale 1ns/1ps
`default_nettype none
module test_gp4_port;
  // ==========
  // Stimulus and observed signals
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, rdv;
  logic [3:0] addrHigh = 4'hA;
  logic [3:0] extVal = 4'h0;
  logic [3:0] extEn = 4'hF; // Board holds pins low until a test lets go
  logic [3:0] pinIn, pinOut, pinOe, pullupOn, mask;
  logic [7:0] sRdata; // Three-pin variant read data
  logic [3:0] sPinOut, sPinOe, sPullupOn; // Three-pin variant pin controls
  int nErrors = 0;
  int checksDone = 0;
  always #12.5 clock = ~clock;
  gp4_port u_gp4_port (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .addrHigh(addrHigh),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn));
  // Three-pin variant on the same bus, so every write reaches both ports
  gp4_port #(.SMALL_VARIANT(1'b1)) u_gp4_port_small (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(sRdata), .addrHigh(addrHigh), .pinIn(pinIn), .pinOut(sPinOut),
    .pinOe(sPinOe), .pullupOn(sPullupOn));
  gp4_pins_model u_gp4_pins_model (.clock(clock), .pinOut(pinOut), .pinOe(pinOe),
    .pullupOn(pullupOn), .extVal(extVal), .extEn(extEn), .pinLevel(pinIn));
  // ==========
  // Helpers; each bus task ends just after a rising edge
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdata;
    @(posedge clock);
  endtask : rd
  // ==========
  // Scenarios
  task automatic t_reset;
    chk({pinOe, pullupOn}, 8'h00);
    wr(3'h2, 8'hFF);
    wr(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], rdv);
      chk(rdv, (a == 6) ? 8'h07 : 8'h00);
    end
  endtask : t_reset
  task automatic t_output;
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'hFA);
    chk({pinOe, pinOut}, 8'hFA);
    rd(3'h2, rdv);
    chk(rdv, 8'h0A);
    wr(3'h4, 8'h0F);
    wr(3'h1, 8'h06);
    chk({pinOe, pinOut}, 8'h90);
    wr(3'h4, 8'h00);
    chk({pinOe, pinOut}, 8'hF6);
    // Write then read with no gap
    regAddr <= 3'h1;
    regWdata <= 8'h35;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk(regRdata, 8'h05);
    @(posedge clock);
  endtask : t_output
  task automatic t_input;
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h0F);
    extEn <= 4'h0;
    repeat (4) @(posedge clock);
    chk({4'h0, pullupOn}, 8'h0F);
    rd(3'h2, rdv);
    chk(rdv, 8'h0F);
    extEn <= 4'hF;
    extVal <= 4'h6;
    repeat (4) @(posedge clock);
    rd(3'h2, rdv);
    chk(rdv, 8'h06);
    wr(3'h0, 8'h0F);
    chk({4'h0, pullupOn}, 8'h00);
    rd(3'h2, rdv);
    chk(rdv, 8'h05);
  endtask : t_input
  task automatic t_addr;
    wr(3'h0, 8'h00);
    for (int m = 4; m < 8; m++) begin
      for (int e = 8; e < 13; e++) begin
        wr(3'h6, 8'(m));
        wr(3'h5, 8'(e));
        mask = {e >= 12, e >= 11, e >= 10, e >= 9} & {4{m < 7}};
        chk({pinOe, pinOut & mask}, {mask, addrHigh & mask});
        chk({4'h0, pullupOn}, {4'h0, ~mask});
      end
    end
  endtask : t_addr
  // Three-pin variant: pin0 absent, no address outputs in external modes
  task automatic t_small;
    wr(3'h0, 8'hFF);
    wr(3'h1, 8'hFF);
    wr(3'h6, 8'h04);
    wr(3'h5, 8'h0F);
    chk({sPinOe, sPinOut}, 8'hEE);
    chk({4'h0, sPullupOn}, 8'h00);
    regAddr <= 3'h1;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk(sRdata, 8'h0E);
    @(posedge clock);
  endtask : t_small
  // ==========
  // Verdict, the one place the run ends
  task automatic conclude;
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset;
    t_output;
    t_input;
    t_addr;
    t_small;
    conclude;
  end
  // Watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    nErrors++;
    conclude;
  end
endmodule : test_gp4_port
`default_nettype wire
